// >>> verilog/aivs_top.sv
// reported-value logic of a two-channel analog current input
`include "aivs_cfg.svh"

module aivs_top
	import aivs_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = `AIVS_CYCLE_CLKS,
	parameter aivs_word_t LEG_OVER_END = `AIVS_LEG_OVER_END,
	parameter aivs_word_t LEG_UNDER_END = `AIVS_LEG_UNDER_END
) (
	input wire logic mclk,
	input wire logic reset,
	input wire aivs_conv_t [1:0] conv,
	input wire logic [1:0] chan_off,
	input wire logic params_ok,
	input wire logic param_load,
	input wire logic load_ok,
	output aivs_out_t [1:0] chan_out,
	output logic upd
);

	// ****************************************************
	// parameter check
	// ****************************************************

	if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65536) begin : g_bad_cycle
		$error("aivs_top: CYCLE_CLKS out of range");
	end

	localparam logic [15:0] LAST_CNT = 16'(CYCLE_CLKS - 1);

	// ****************************************************
	// state and channel selection
	// ****************************************************

	aivs_state_t st_q;
	aivs_state_t st_d;
	logic tick;
	logic [1:0] subst;
	aivs_out_t [1:0] sel;

	// end of a conversion cycle, counted with every channel in it
	assign tick = (st_q.cnt == LAST_CNT);

	// substitute conditions per channel; run or stop is no condition
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			subst[i] = !load_ok
				|| !params_ok
				|| st_q.pend
				|| chan_off[i];
		end
	end

	// one selector per channel
	for (genvar g = 0; g < 2; g++) begin : g_ch
		aivs_chan_sel #(
			.LEG_OVER_END(LEG_OVER_END),
			.LEG_UNDER_END(LEG_UNDER_END)
		) u_sel (
			.conv(conv[g]),
			.subst(subst[g]),
			.word(sel[g])
		);
	end

	// next state: counter, first-conversion flag, word refresh
	always_comb begin
		st_d = st_q;
		st_d.upd = 1'b0;
		if (tick) begin
			st_d.cnt = 16'h0000;
			st_d.upd = 1'b1;
			st_d.pend = 1'b0;
			st_d.out = sel;
		end else begin
			st_d.cnt = st_q.cnt + 16'h0001;
		end
		// a load in the tick cycle still discards the next result
		if (param_load) begin
			st_d.pend = 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_q.cnt <= `AIVS_RST_CNT;
			st_q.pend <= `AIVS_RST_PEND;
			st_q.upd <= 1'b0;
			st_q.out <= {4{`AIVS_SUBST_WORD}};
		end else begin
			st_q <= st_d;
		end
	end

	assign chan_out = st_q.out;
	assign upd = st_q.upd;

	// ****************************************************
	// assertions
	// ****************************************************

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// live refresh of one channel whose range class is in rng_set
	sequence s_tick_live(int ch, logic [3:0] rng_set);
		tick && load_ok && params_ok && !st_q.pend && !chan_off[ch]
			&& rng_set[conv[ch].rng];
	endsequence

	sequence s_subst_out(int ch);
		chan_out[ch].prim == `AIVS_SUBST_WORD
			&& chan_out[ch].leg == `AIVS_SUBST_WORD;
	endsequence

	for (genvar c = 0; c < 2; c++) begin : g_chk
		property p_measured;
			aivs_word_t p;
			aivs_word_t l;
			(s_tick_live(c, 4'h3), p = conv[c].prim, l = conv[c].leg)
				|=> chan_out[c].prim == p && chan_out[c].leg == l;
		endproperty
		a_measured: assert property (p_measured)
			else $error("measured value not reported");

		property p_ovfl;
			s_tick_live(c, 4'h4) |=>
				chan_out[c].prim == 16'h7FFF
				&& chan_out[c].leg == ((LEG_OVER_END + 16'h0001)
				| (16'h0001 << `AIVS_LEG_OVF_BIT));
		endproperty
		a_ovfl: assert property (p_ovfl)
			else $error("wrong overflow words");

		property p_unfl;
			s_tick_live(c, 4'h8) |=>
				chan_out[c].prim == 16'h8000
				&& chan_out[c].prim[`AIVS_SIGN_BIT]
				&& chan_out[c].leg == ((LEG_UNDER_END - 16'h0001)
				| (16'h0001 << `AIVS_LEG_OVF_BIT));
		endproperty
		a_unfl: assert property (p_unfl)
			else $error("wrong underflow words");

		property p_badpar;
			tick && !params_ok |=> s_subst_out(c);
		endproperty
		a_badpar: assert property (p_badpar)
			else $error("faulty parameters not substituted");

		property p_noload;
			tick && !load_ok |=> s_subst_out(c);
		endproperty
		a_noload: assert property (p_noload)
			else $error("missing supply not substituted");

		property p_off;
			tick && chan_off[c] |=> s_subst_out(c);
		endproperty
		a_off: assert property (p_off)
			else $error("deactivated channel not substituted");

		property p_hold;
			!tick |=> $stable(chan_out[c]);
		endproperty
		a_hold: assert property (p_hold)
			else $error("word changed between cycle ends");
	end

	// a finished load marks the next result as stale, tick or not
	property p_pend_set;
		param_load |=> st_q.pend;
	endproperty
	a_pend_set: assert property (p_pend_set)
		else $error("parameter load did not mark result stale");

	// a stale result never reaches the words
	property p_first;
		tick && st_q.pend |=> s_subst_out(0) and s_subst_out(1);
	endproperty
	a_first: assert property (p_first)
		else $error("result after parameter load not discarded");

	property p_cycle;
		upd |-> st_q.cnt == 16'h0000 ##1 !upd;
	endproperty
	a_cycle: assert property (p_cycle)
		else $error("conversion cycle cut short");

	property p_period;
		tick |-> $past(st_q.cnt) == LAST_CNT - 16'h0001 || $past(tick);
	endproperty
	a_period: assert property (p_period)
		else $error("cycle counter skipped");

endmodule : aivs_top

// >>> verilog/aivs_cfg.svh
// constants of the analog input value substitution block
`ifndef AIVS_CFG_SVH
`define AIVS_CFG_SVH

// substitute words
`define AIVS_SUBST_WORD 16'h7FFF
`define AIVS_UFLOW_WORD 16'h8000
// sign position of every reported word
`define AIVS_SIGN_BIT 15
// overflow flag position in the legacy word
`define AIVS_LEG_OVF_BIT 0
// legacy range ends, plain defaults
`define AIVS_LEG_OVER_END 16'h7F00
`define AIVS_LEG_UNDER_END 16'h8100
// conversion cycle time and clock rate
`define AIVS_CYCLE_US 250
`define AIVS_MCLK_HZ 25000000
`define AIVS_CYCLE_CLKS (`AIVS_CYCLE_US * (`AIVS_MCLK_HZ / 1000000))
// reset values
`define AIVS_RST_CNT 16'h0000
`define AIVS_RST_PEND 1'b1

`endif

// >>> verilog/aivs_pkg.sv
// types of the analog input value substitution block
package aivs_pkg;

	typedef logic [15:0] aivs_word_t;

	// where the converted input falls in the value range
	typedef enum logic [1:0] {
		AIVS_RNG_NOMINAL = 2'b00,
		AIVS_RNG_OUTER = 2'b01,
		AIVS_RNG_OVFL = 2'b10,
		AIVS_RNG_UNFL = 2'b11
	} aivs_rng_t;

	// one finished conversion of one channel
	typedef struct packed {
		aivs_rng_t rng;
		aivs_word_t prim;
		aivs_word_t leg;
	} aivs_conv_t;

	// reported words of one channel
	typedef struct packed {
		aivs_word_t prim;
		aivs_word_t leg;
	} aivs_out_t;

	// whole state of the top module
	typedef struct packed {
		logic [15:0] cnt;
		logic pend;
		logic upd;
		aivs_out_t [1:0] out;
	} aivs_state_t;

endpackage : aivs_pkg

// >>> verilog/aivs_chan_sel.sv
// per-channel choice between converted value and substitute
`include "aivs_cfg.svh"

module aivs_chan_sel
	import aivs_pkg::*;
#(
	parameter aivs_word_t LEG_OVER_END = `AIVS_LEG_OVER_END,
	parameter aivs_word_t LEG_UNDER_END = `AIVS_LEG_UNDER_END
) (
	input wire aivs_conv_t conv,
	input wire logic subst,
	output aivs_out_t word
);

	// legacy overflow and underflow words both carry the overflow flag
	localparam aivs_word_t LEG_OVF_MASK = 16'h0001 << `AIVS_LEG_OVF_BIT;

	// substitute first, then range class
	always_comb begin
		word.prim = `AIVS_SUBST_WORD;
		word.leg = `AIVS_SUBST_WORD;
		if (!subst) begin
			unique case (conv.rng)
				AIVS_RNG_NOMINAL,
				AIVS_RNG_OUTER: begin
					word.prim = conv.prim;
					word.leg = conv.leg;
				end
				AIVS_RNG_OVFL: begin
					word.prim = `AIVS_SUBST_WORD;
					word.leg = (LEG_OVER_END + 16'h0001) | LEG_OVF_MASK;
				end
				AIVS_RNG_UNFL: begin
					word.prim = `AIVS_UFLOW_WORD;
					word.leg = (LEG_UNDER_END - 16'h0001) | LEG_OVF_MASK;
				end
			endcase
		end
	end

endmodule : aivs_chan_sel

// >>> verif/aivs_conv_model.sv
// converter front end model that hands finished results to the block
module aivs_conv_model
	import aivs_pkg::*;
(
	input wire logic mclk,
	input wire aivs_conv_t [1:0] req,
	output aivs_conv_t [1:0] conv
);
	timeunit 1ns;
	timeprecision 1ps;

	// a result appears one clock after it is requested
	always_ff @(posedge mclk) begin
		conv <= req;
	end

endmodule : aivs_conv_model

// >>> verif/analog_input_value_substitution_tb.sv
// self-checking bench of the value substitution block
module analog_input_value_substitution_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import aivs_pkg::*;

	localparam int unsigned CYC = 8;
	localparam aivs_word_t OVER = 16'h7F00;
	localparam aivs_word_t UNDER = 16'h8100;
	localparam aivs_word_t SUB = 16'h7FFF;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	aivs_conv_t [1:0] req = '0;
	aivs_conv_t [1:0] conv;
	logic [1:0] chan_off = 2'b00;
	logic params_ok = 1'b1;
	logic param_load = 1'b0;
	logic load_ok = 1'b1;
	aivs_out_t [1:0] chan_out;
	logic upd;
	aivs_out_t [1:0] exp_q[$];
	int n_fail = 0;
	int tests_run = 0;
	int gap = -1;

	aivs_conv_model u_model (.mclk(mclk), .req(req), .conv(conv));

	aivs_top #(.CYCLE_CLKS(CYC), .LEG_OVER_END(OVER),
		.LEG_UNDER_END(UNDER)) u_dut (
		.mclk(mclk), .reset(reset), .conv(conv), .chan_off(chan_off),
		.params_ok(params_ok), .param_load(param_load),
		.load_ok(load_ok), .chan_out(chan_out), .upd(upd));

	// ****************************************
	// helpers
	// ****************************************
	function automatic aivs_out_t pick(aivs_conv_t c, logic s);
		aivs_out_t w;
		w.prim = c.prim;
		w.leg = c.leg;
		if (s) begin
			w = {SUB, SUB};
		end else if (c.rng == AIVS_RNG_OVFL) begin
			w = {SUB, (OVER + 16'h0001) | 16'h0001};
		end else if (c.rng == AIVS_RNG_UNFL) begin
			w = {16'h8000, (UNDER - 16'h0001) | 16'h0001};
		end
		return w;
	endfunction : pick

	task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	// 25 MHz clock
	initial begin
		forever #20 mclk = ~mclk;
	end

	// driver: new inputs right after each refresh, held a whole cycle except param_load, which is pulsed for one clock
	initial begin
		aivs_out_t [1:0] e;
		aivs_conv_t [1:0] r;
		logic [1:0] off;
		logic lo, po, pl;
		void'($urandom(80));
		repeat (16) @(posedge mclk);
		check("reset words", chan_out, {4{SUB}});
		check("reset pulse", upd, 1'b0);
		reset <= 1'b0;
		exp_q.push_back({4{SUB}});
		for (int i = 0; i < 48; i++) begin
			do @(negedge mclk); while (upd !== 1'b1);
			@(posedge mclk);
			for (int c = 0; c < 2; c++) begin
				r[c].rng = aivs_rng_t'(c == 0 ? i % 4 : $urandom % 4);
				r[c].prim = 16'($urandom);
				r[c].leg = 16'($urandom);
			end
			off = 2'(($urandom % 4 == 0) ? 1 + i % 2 : 0);
			lo = (i % 5 != 3);
			po = (i % 7 != 4);
			pl = (i % 9 == 6);
			req <= r;
			chan_off <= off;
			load_ok <= lo;
			params_ok <= po;
			param_load <= pl;
			for (int c = 0; c < 2; c++) begin
				e[c] = pick(r[c], pl | !lo | !po | off[c]);
			end
			exp_q.push_back(e);
			@(posedge mclk);
			param_load <= 1'b0;
		end
		do @(negedge mclk); while (upd !== 1'b1);
		@(negedge mclk);
		wrap_up();
	end

	// monitor: each refresh takes the oldest note and the cycle length
	always @(negedge mclk) begin
		if (!reset) begin
			gap++;
		end
		if (upd === 1'b1) begin
			check("words", chan_out, exp_q.pop_front());
			check("cycle length", gap, CYC);
			gap = 0;
		end
	end

	// watchdog well past the expected run
	initial begin
		repeat (16 + 100 * CYC) @(posedge mclk);
		check("watchdog", 1'b1, 1'b0);
		wrap_up();
	end

endmodule : analog_input_value_substitution_tb
